// >>> sqt_adc_model.sv
// Behavioural converter model answering the scan sequencer
module sqt_adc_model
	import sqt_pkg::*;
(
	input wire logic CLK,
	input wire logic ADC_START,
	input wire logic [1:0] ADC_SRC,
	input wire logic [5:0] ADC_CH,
	output logic [15:0] ADC_DATA
);
	logic [5:0] busy_q = 6'h00;
	logic [15:0] res_q = 16'h0000;
	logic [15:0] code;
	initial ADC_DATA = 16'h0000;
	// Shorted input reads zero; others encode source and channel
	assign code = (ADC_SRC == SRC_ZERO) ? 16'h0000 :
		{4'hA, ADC_SRC, 4'h0, ADC_CH};
	// Output toggles while converting, result after 20 cycles
	always @(posedge CLK) begin
		if (ADC_START) begin
			busy_q <= 6'h14;
			res_q <= code;
			ADC_DATA <= ~ADC_DATA;
		end else if (busy_q != 6'h00) begin
			busy_q <= busy_q - 6'h01;
			ADC_DATA <= (busy_q == 6'h01) ? res_q : ~ADC_DATA;
		end
	end
endmodule

// >>> sqt_avg.sv
// Oversampling accumulator with power-of-two average
module sqt_avg
	import sqt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic add,
	input wire logic [15:0] data,
	input wire logic [3:0] log2,
	output logic [15:0] avg
);
	logic [29:0] sum_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sum_q <= '0;
		end else if (clr) begin
			sum_q <= '0;
		end else if (add) begin
			sum_q <= sum_q + 30'(data);
		end
	end

	assign avg = 16'(sum_q >> log2);
endmodule

// >>> sqt_pkg.sv
// Constants, register map and types of the scan sequencer
package sqt_pkg;
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SLOT_NS = 1000;
	localparam int SLOT_CYC = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint unsigned SCAN_MAX_HOURS = 64'd19;
	localparam longint unsigned SCAN_MAX_NS =
		SCAN_MAX_HOURS * 64'd3600 * 64'd1000000000;
	localparam longint unsigned SCAN_MAX_CYC =
		SCAN_MAX_NS / 64'(CLK_PERIOD_NS);
	localparam int DELAY_W = 48;
	// Sizes
	localparam int GROUP_DEPTH = 512;
	localparam int GROUP_AW = 9;
	localparam int BUF_DEPTH = 1000000;
	localparam int BUF_AW = 20;
	localparam logic [BUF_AW-1:0] BUF_LAST = 20'(BUF_DEPTH - 1);
	localparam int NUM_CNT = 4;
	localparam int EMIT_ITEMS = 2 + 2 * NUM_CNT;
	localparam logic [2:0] CJC_PER_BLOCK = 3'h3;
	localparam logic [3:0] OVS_LOG2_MAX = 4'hE;
	localparam logic [2:0] RANGE_MAX = 3'h6;
	// Register byte addresses
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_GROUP_LEN = 8'h0C;
	localparam logic [7:0] REG_TBL_ADDR = 8'h10;
	localparam logic [7:0] REG_TBL_DATA = 8'h14;
	localparam logic [7:0] REG_DELAY_LO = 8'h18;
	localparam logic [7:0] REG_DELAY_HI = 8'h1C;
	localparam logic [7:0] REG_TEMP_MASK = 8'h20;
	localparam logic [7:0] REG_CNT_CFG = 8'h24;
	localparam logic [7:0] REG_TRIG_LEVEL = 8'h28;
	localparam logic [7:0] REG_TRIG_CFG = 8'h2C;
	localparam logic [7:0] REG_WPTR = 8'h30;
	// Configuration fields
	localparam int CFG_PER_SAMPLE = 0;
	localparam int CFG_AUTOZERO = 1;
	localparam int CFG_TRIG_EN = 2;
	localparam int CFG_TRIG_FALL = 3;
	localparam int CFG_DIN_EN = 4;
	localparam int CFG_DIN_W_LSB = 5;
	localparam int CFG_OVS_LSB = 8;
	localparam int CMD_ARM = 0;
	localparam int CMD_STOP = 1;
	localparam logic [1:0] DINW_8 = 2'h0;
	localparam logic [1:0] DINW_24 = 2'h2;
	// Scan entry: channel, range, differential
	localparam int ENT_W = 10;
	localparam int ENT_RANGE_LSB = 6;
	localparam int ENT_DIFF = 9;
	// Converter source select
	localparam logic [1:0] SRC_INPUT = 2'h0;
	localparam logic [1:0] SRC_CJC = 2'h1;
	localparam logic [1:0] SRC_ZERO = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_SLOT, ST_DELAY} sqt_state_t;
endpackage

// >>> sqt_scan_seq.sv
// Scan sequencer with analog level trigger and sample packing
//
// Contract
// - Each analog entry gets one 1 us conversion slot.
// - Inter-scan delay extends the scan period up to 19 hours.
// - Temperature inputs 0-7 add three cold-junction slots per block.
// - Autozero adds a shorted-input slot to each scan.
// - Each entry carries its own range (one of seven) and diff select.
// - Once-per-scan mode captures digital and counters at scan start.
// - Per-sample mode captures digital word with every analog slot.
// - No digital capture during the idle delay of a scan.
// - Each counter returns low 16 bits or full 32 bits.
// - Digital entry returns 8, 16 or 24 bits.
// - Samples are 16 bits; 32-bit counts go low word then high.
// - Each counter has its own counting function select.
// - Samples go to a one-million-sample buffer.
// - Trigger level drives reference converter; start within 1.3 us.
// - Trigger source channel, level, edge and hysteresis programmable.
// - Trigger fires only on a comparator transition after arming.
// - Oversampling averages consecutive conversions per analog slot.
// - 512-entry group; repeat at once or after programmable delay.
//
// Design decisions made here: the address-and-strobe port and the address map.
module sqt_scan_seq
	import sqt_pkg::*;
#(
	parameter logic [DELAY_W-1:0] MAX_DELAY_CYC = 48'(SCAN_MAX_CYC)
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	output logic ADC_START,
	output logic [1:0] ADC_SRC,
	output logic [5:0] ADC_CH,
	output logic [2:0] ADC_RANGE,
	output logic ADC_DIFF,
	input wire logic [15:0] ADC_DATA,
	input wire logic [23:0] DIN,
	input wire logic [32*NUM_CNT-1:0] CNT_VAL,
	output logic [2*NUM_CNT-1:0] CNT_MODE,
	input wire logic CMP,
	output logic [15:0] TRIG_DAC,
	output logic [5:0] TRIG_CH,
	output logic [7:0] TRIG_HYST,
	output logic TRIG_FALL,
	output logic BUF_WE,
	output logic [BUF_AW-1:0] BUF_WADDR,
	output logic [15:0] BUF_WDATA,
	output logic RUN
);
	logic [15:0] cfg_q;
	logic [9:0] group_len_q;
	logic [GROUP_AW-1:0] tbl_addr_q;
	logic [ENT_W-1:0] tbl_mem [GROUP_DEPTH];
	logic [DELAY_W-1:0] delay_q;
	logic [7:0] temp_mask_q;
	logic [15:0] cnt_cfg_q;
	logic [15:0] trig_level_q;
	logic [13:0] trig_cfg_q;
	sqt_state_t state_q;
	logic [10:0] ent_q;
	logic [14:0] conv_q;
	logic [5:0] cyc_q;
	logic [DELAY_W-1:0] delay_cnt_q;
	logic [15:0] scan_cnt_q;
	logic cmp_s, cmp_prev_q;
	logic [23:0] din_s, din_snap_q;
	logic [15:0] adc_s, avg;
	logic [32*NUM_CNT-1:0] cnt_snap_q;
	logic emit_din_q, emit_cnt_q, res_pend_q;
	logic [3:0] sel_q;
	logic [BUF_AW-1:0] wptr_q;
	logic run_q;

	sqt_sync #(.W(1)) u_cmp_sync (.clk(CLK), .rst_n(NRST), .d(CMP), .q(cmp_s));
	sqt_sync #(.W(24)) u_din_sync (.clk(CLK), .rst_n(NRST), .d(DIN),
		.q(din_s));
	sqt_sync #(.W(16)) u_adc_sync (.clk(CLK), .rst_n(NRST), .d(ADC_DATA),
		.q(adc_s));

	// Derived configuration
	logic cmd_arm, cmd_stop, blk0, blk1, fire;
	logic [2:0] cjc_n;
	logic [10:0] total_n;
	logic [3:0] ovs;
	logic [14:0] conv_last;
	logic [DELAY_W-1:0] delay_eff;
	logic slot_begin, conv_end, slot_end, last_ent;

	assign cmd_arm = WR && ADDR == REG_CMD && WDATA[CMD_ARM];
	assign cmd_stop = WR && ADDR == REG_CMD && WDATA[CMD_STOP];
	assign blk0 = |temp_mask_q[3:0];
	assign blk1 = |temp_mask_q[7:4];
	assign cjc_n = (blk0 ? CJC_PER_BLOCK : 3'h0) + (blk1 ? CJC_PER_BLOCK : 3'h0);
	assign total_n = 11'(group_len_q) + 11'(cjc_n) + 11'(cfg_q[CFG_AUTOZERO]);
	assign ovs = cfg_q[CFG_OVS_LSB +: 4] > OVS_LOG2_MAX ? OVS_LOG2_MAX :
		cfg_q[CFG_OVS_LSB +: 4];
	assign conv_last = 15'((32'h1 << ovs) - 32'h1);
	assign delay_eff = delay_q > MAX_DELAY_CYC ? MAX_DELAY_CYC : delay_q;
	assign slot_begin = state_q == ST_SLOT && cyc_q == 6'h0 && conv_q == 15'h0;
	assign conv_end = state_q == ST_SLOT && cyc_q == 6'(SLOT_CYC - 1);
	assign slot_end = conv_end && conv_q == conv_last;
	assign last_ent = ent_q >= total_n - 11'h1;
	assign fire = cfg_q[CFG_TRIG_FALL] ? (cmp_prev_q && !cmp_s) :
		(!cmp_prev_q && cmp_s);

	// Entry decode: group, then cold junctions, then autozero
	logic [1:0] ent_src;
	logic [5:0] ent_ch;
	logic [2:0] ent_range;
	logic ent_diff;
	logic [ENT_W-1:0] ent_word;
	logic [10:0] cjc_idx;

	always_comb begin
		ent_word = tbl_mem[ent_q[GROUP_AW-1:0]];
		cjc_idx = ent_q - 11'(group_len_q);
		ent_src = SRC_ZERO;
		ent_ch = 6'h00;
		ent_range = 3'h0;
		ent_diff = 1'b0;
		if (ent_q < 11'(group_len_q)) begin
			ent_src = SRC_INPUT;
			ent_ch = ent_word[5:0];
			ent_range = ent_word[ENT_RANGE_LSB +: 3];
			ent_diff = ent_word[ENT_DIFF];
		end else if (cjc_idx < 11'(cjc_n)) begin
			ent_src = SRC_CJC;
			ent_ch = blk0 ? 6'(cjc_idx) : 6'(cjc_idx) + 6'(CJC_PER_BLOCK);
		end
	end

	// Register writes
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cfg_q <= 16'h0000;
			group_len_q <= 10'h000;
			tbl_addr_q <= '0;
			delay_q <= '0;
			temp_mask_q <= 8'h00;
			cnt_cfg_q <= 16'h0000;
			trig_level_q <= 16'h0000;
			trig_cfg_q <= 14'h0000;
		end else if (WR) begin
			if (ADDR == REG_CFG) begin
				cfg_q <= WDATA[15:0];
			end else if (ADDR == REG_GROUP_LEN) begin
				group_len_q <= WDATA[9:0] > 10'(GROUP_DEPTH) ?
					10'(GROUP_DEPTH) : WDATA[9:0];
			end else if (ADDR == REG_TBL_ADDR) begin
				tbl_addr_q <= WDATA[GROUP_AW-1:0];
			end else if (ADDR == REG_TBL_DATA) begin
				tbl_addr_q <= tbl_addr_q + 9'h001;
			end else if (ADDR == REG_DELAY_LO) begin
				delay_q[31:0] <= WDATA;
			end else if (ADDR == REG_DELAY_HI) begin
				delay_q[DELAY_W-1:32] <= WDATA[DELAY_W-33:0];
			end else if (ADDR == REG_TEMP_MASK) begin
				temp_mask_q <= WDATA[7:0];
			end else if (ADDR == REG_CNT_CFG) begin
				cnt_cfg_q <= WDATA[15:0];
			end else if (ADDR == REG_TRIG_LEVEL) begin
				trig_level_q <= WDATA[15:0];
			end else if (ADDR == REG_TRIG_CFG) begin
				trig_cfg_q <= WDATA[13:0];
			end
		end
	end

	// Scan group table, range code clamped to the seven ranges
	always_ff @(posedge CLK) begin
		if (WR && ADDR == REG_TBL_DATA) begin
			tbl_mem[tbl_addr_q] <= {WDATA[ENT_DIFF],
				WDATA[ENT_RANGE_LSB +: 3] > RANGE_MAX ? RANGE_MAX :
				WDATA[ENT_RANGE_LSB +: 3], WDATA[5:0]};
		end
	end

	// Register reads, data valid the cycle after the strobe
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= 32'h00000000;
		end else if (RD) begin
			if (ADDR == REG_CFG) begin
				RDATA <= {16'h0000, cfg_q};
			end else if (ADDR == REG_STATUS) begin
				RDATA <= {scan_cnt_q, 13'h0000, state_q == ST_ARMED,
					run_q, state_q != ST_IDLE};
			end else if (ADDR == REG_GROUP_LEN) begin
				RDATA <= {22'h000000, group_len_q};
			end else if (ADDR == REG_TBL_ADDR) begin
				RDATA <= {23'h000000, tbl_addr_q};
			end else if (ADDR == REG_TBL_DATA) begin
				RDATA <= {22'h000000, tbl_mem[tbl_addr_q]};
			end else if (ADDR == REG_DELAY_LO) begin
				RDATA <= delay_q[31:0];
			end else if (ADDR == REG_DELAY_HI) begin
				RDATA <= {16'h0000, delay_q[DELAY_W-1:32]};
			end else if (ADDR == REG_TEMP_MASK) begin
				RDATA <= {24'h000000, temp_mask_q};
			end else if (ADDR == REG_CNT_CFG) begin
				RDATA <= {16'h0000, cnt_cfg_q};
			end else if (ADDR == REG_TRIG_LEVEL) begin
				RDATA <= {16'h0000, trig_level_q};
			end else if (ADDR == REG_TRIG_CFG) begin
				RDATA <= {18'h00000, trig_cfg_q};
			end else if (ADDR == REG_WPTR) begin
				RDATA <= {12'h000, wptr_q};
			end else begin
				RDATA <= 32'h00000000;
			end
		end else begin
			RDATA <= 32'h00000000;
		end
	end

	// Comparator history, kept every cycle so arming sees no stale edge
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cmp_prev_q <= 1'b0;
		end else begin
			cmp_prev_q <= cmp_s;
		end
	end

	// Sequencer
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_q <= ST_IDLE;
			ent_q <= 11'h000;
			conv_q <= 15'h0000;
			cyc_q <= 6'h00;
			delay_cnt_q <= '0;
			scan_cnt_q <= 16'h0000;
		end else if (cmd_stop) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
			ST_IDLE: begin
				if (cmd_arm && total_n != 11'h000) begin
					state_q <= ST_ARMED;
					scan_cnt_q <= 16'h0000;
				end
			end
			ST_ARMED: begin
				if (!cfg_q[CFG_TRIG_EN] || fire) begin
					state_q <= ST_SLOT;
					ent_q <= 11'h000;
					conv_q <= 15'h0000;
					cyc_q <= 6'h00;
				end
			end
			ST_SLOT: begin
				if (cyc_q == 6'(SLOT_CYC - 1)) begin
					cyc_q <= 6'h00;
					if (conv_q >= conv_last) begin
						conv_q <= 15'h0000;
						if (last_ent) begin
							ent_q <= 11'h000;
							scan_cnt_q <= scan_cnt_q + 16'h0001;
							if (delay_eff != '0) begin
								state_q <= ST_DELAY;
								delay_cnt_q <= delay_eff - 48'h1;
							end
						end else begin
							ent_q <= ent_q + 11'h001;
						end
					end else begin
						conv_q <= conv_q + 15'h0001;
					end
				end else begin
					cyc_q <= cyc_q + 6'h01;
				end
			end
			ST_DELAY: begin
				if (delay_cnt_q == '0) begin
					state_q <= ST_SLOT;
				end else begin
					delay_cnt_q <= delay_cnt_q - 48'h1;
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Converter control
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ADC_START <= 1'b0;
			ADC_SRC <= SRC_INPUT;
			ADC_CH <= 6'h00;
			ADC_RANGE <= 3'h0;
			ADC_DIFF <= 1'b0;
			run_q <= 1'b0;
		end else begin
			ADC_START <= state_q == ST_SLOT && cyc_q == 6'h00 && !cmd_stop;
			ADC_SRC <= ent_src;
			ADC_CH <= ent_ch;
			ADC_RANGE <= ent_range;
			ADC_DIFF <= ent_diff;
			run_q <= state_q == ST_SLOT || state_q == ST_DELAY;
		end
	end

	sqt_avg u_avg (
		.clk(CLK),
		.rst_n(NRST),
		.clr(slot_begin),
		.add(conv_end),
		.data(adc_s),
		.log2(ovs),
		.avg(avg)
	);

	// Capture of digital word and counters at slot start
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			din_snap_q <= 24'h000000;
			cnt_snap_q <= '0;
			emit_din_q <= 1'b0;
			emit_cnt_q <= 1'b0;
			sel_q <= 4'(EMIT_ITEMS);
			res_pend_q <= 1'b0;
		end else begin
			res_pend_q <= slot_end;
			if (slot_begin) begin
				din_snap_q <= din_s;
				emit_din_q <= cfg_q[CFG_DIN_EN] &&
					(ent_q == 11'h000 || cfg_q[CFG_PER_SAMPLE]);
				emit_cnt_q <= ent_q == 11'h000;
				if (ent_q == 11'h000) begin
					cnt_snap_q <= CNT_VAL;
				end
				sel_q <= 4'h0;
			end else if (sel_q != 4'(EMIT_ITEMS)) begin
				sel_q <= sel_q + 4'h1;
			end
		end
	end

	// Item walk: digital low, digital high, counters low then high
	logic item_en;
	logic [15:0] item_word;
	logic [3:0] item_k;
	logic [1:0] din_w;
	logic [31:0] cnt_word;

	always_comb begin
		item_k = sel_q - 4'h2;
		din_w = cfg_q[CFG_DIN_W_LSB +: 2];
		cnt_word = cnt_snap_q[32*item_k[2:1] +: 32];
		item_en = 1'b0;
		item_word = 16'h0000;
		if (sel_q == 4'h0) begin
			item_en = emit_din_q;
			item_word = din_w == DINW_8 ? {8'h00, din_snap_q[7:0]} :
				din_snap_q[15:0];
		end else if (sel_q == 4'h1) begin
			item_en = emit_din_q && din_w == DINW_24;
			item_word = {8'h00, din_snap_q[23:16]};
		end else if (sel_q < 4'(EMIT_ITEMS)) begin
			item_en = emit_cnt_q && cnt_cfg_q[item_k[2:1]] &&
				(!item_k[0] || cnt_cfg_q[NUM_CNT + 32'(item_k[2:1])]);
			item_word = item_k[0] ? cnt_word[31:16] : cnt_word[15:0];
		end
	end

	// Sample buffer write port
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			BUF_WE <= 1'b0;
			BUF_WADDR <= '0;
			BUF_WDATA <= 16'h0000;
			wptr_q <= '0;
		end else if (state_q == ST_IDLE && cmd_arm) begin
			BUF_WE <= 1'b0;
			wptr_q <= '0;
		end else if (res_pend_q || item_en) begin
			BUF_WE <= 1'b1;
			BUF_WADDR <= wptr_q;
			BUF_WDATA <= res_pend_q ? avg : item_word;
			wptr_q <= wptr_q == BUF_LAST ? '0 : wptr_q + 20'h1;
		end else begin
			BUF_WE <= 1'b0;
		end
	end

	assign CNT_MODE = cnt_cfg_q[15:8];
	assign TRIG_DAC = trig_level_q;
	assign TRIG_CH = trig_cfg_q[5:0];
	assign TRIG_HYST = trig_cfg_q[13:6];
	assign TRIG_FALL = cfg_q[CFG_TRIG_FALL];
	assign RUN = run_q;
endmodule

// >>> sqt_scan_seq_sva.sv
// Port checker for the scan sequencer
module sqt_scan_chk
	import sqt_pkg::*;
#(
	parameter logic [DELAY_W-1:0] MAX_DELAY_CYC = 48'h64
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	input wire logic ADC_START,
	input wire logic [1:0] ADC_SRC,
	input wire logic [5:0] ADC_CH,
	input wire logic [2:0] ADC_RANGE,
	input wire logic ADC_DIFF,
	input wire logic BUF_WE,
	input wire logic [BUF_AW-1:0] BUF_WADDR,
	input wire logic RUN
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	logic [15:0] gap_q;
	logic seen_q;
	logic [BUF_AW-1:0] last_q;
	logic have_q;
	// Cycles since the last converter start
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			gap_q <= 16'h0000;
			seen_q <= 1'b0;
		end else if (ADC_START) begin
			gap_q <= 16'h0001;
			seen_q <= 1'b1;
		end else begin
			// A stopped run cuts its slot; a new run times afresh
			seen_q <= seen_q && RUN;
			if (gap_q != 16'hFFFF) begin
				gap_q <= gap_q + 16'h0001;
			end
		end
	end
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			last_q <= 20'h00000;
			have_q <= 1'b0;
		end else if (BUF_WE) begin
			last_q <= BUF_WADDR;
			have_q <= 1'b1;
		end else if (!RUN) begin
			// Arming restarts the buffer address
			have_q <= 1'b0;
		end
	end
	sequence s_first_conv;
		##[0:2] ADC_START;
	endsequence
	sequence s_sel_hold;
		($stable({ADC_SRC, ADC_CH, ADC_RANGE, ADC_DIFF}) || !RUN)[*8];
	endsequence
	property p_slot_gap;
		ADC_START && seen_q |-> gap_q >= 16'(SLOT_CYC);
	endproperty
	a_slot_gap: assert property (p_slot_gap) else $error("slot short");
	property p_idle_quiet;
		!RUN |-> !ADC_START;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle start");
	property p_sel_hold;
		ADC_START |-> ##1 s_sel_hold;
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("select moved");
	property p_range_max;
		ADC_START |-> ADC_RANGE <= RANGE_MAX;
	endproperty
	a_range_max: assert property (p_range_max) else $error("bad range");
	property p_addr_step;
		BUF_WE && have_q |->
			BUF_WADDR == ((last_q == BUF_LAST) ? 20'h00000 : last_q + 20'h00001);
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("addr skip");
	property p_addr_max;
		BUF_WE |-> BUF_WADDR <= BUF_LAST;
	endproperty
	a_addr_max: assert property (p_addr_max) else $error("addr range");
	property p_rdata_idle;
		!RD |=> RDATA == 32'h00000000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("rdata held");
	property p_run_start;
		$rose(RUN) |-> s_first_conv;
	endproperty
	a_run_start: assert property (p_run_start) else $error("no start");
endmodule

// >>> sqt_sync.sv
// Two-stage synchroniser for pin inputs
module sqt_sync
	import sqt_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// >>> tb.sv
// Self-checking bench of the scan sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sqt_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} sqt_row_t;
	logic clk, nrst, wr, rd, adc_start, adc_diff, cmp, trig_fall, buf_we, run;
	logic [7:0] addr, trig_hyst, cnt_mode;
	logic [31:0] wdata, rdata, v;
	logic [1:0] adc_src;
	logic [5:0] adc_ch, trig_ch;
	logic [2:0] adc_range;
	logic [15:0] adc_data, trig_dac, buf_wdata;
	logic [23:0] din;
	logic [127:0] cnt_val;
	logic [19:0] buf_waddr;
	logic [15:0] got[$], ex[$];
	logic [11:0] sel[$];
	time st[$];
	int err_total, tests_run;
	sqt_row_t rows[7] = '{'{REG_CFG, 32'h0F5F, 32'h0F5F},
		'{REG_GROUP_LEN, 32'h0258, 32'h0200}, '{REG_TRIG_LEVEL, 32'hBEEF, 32'hBEEF},
		'{REG_TRIG_CFG, 32'h3FFF, 32'h3FFF}, '{REG_TEMP_MASK, 32'hA5, 32'hA5},
		'{REG_STATUS, 32'hFFFF, 32'h0}, '{8'h40, 32'h1234, 32'h0}};
	sqt_scan_seq #(.MAX_DELAY_CYC(48'h64)) uut (.CLK(clk), .NRST(nrst),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.ADC_START(adc_start), .ADC_SRC(adc_src), .ADC_CH(adc_ch),
		.ADC_RANGE(adc_range), .ADC_DIFF(adc_diff), .ADC_DATA(adc_data),
		.DIN(din), .CNT_VAL(cnt_val), .CNT_MODE(cnt_mode), .CMP(cmp),
		.TRIG_DAC(trig_dac), .TRIG_CH(trig_ch), .TRIG_HYST(trig_hyst),
		.TRIG_FALL(trig_fall), .BUF_WE(buf_we), .BUF_WADDR(buf_waddr),
		.BUF_WDATA(buf_wdata), .RUN(run));
	sqt_adc_model adc_i (.CLK(clk), .ADC_START(adc_start), .ADC_SRC(adc_src),
		.ADC_CH(adc_ch), .ADC_DATA(adc_data));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (buf_we) got.push_back(buf_wdata);
		if (adc_start) begin
			sel.push_back({adc_src, adc_ch, adc_range, adc_diff});
			st.push_back($time);
		end
	end
	function automatic logic [15:0] cv(logic [1:0] s, logic [5:0] c);
		return (s == SRC_ZERO) ? 16'h0000 : {4'hA, s, 4'h0, c};
	endfunction
	task automatic wrap_up();
		if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic fail(input string m);
		err_total++;
		$display("[FAIL] %0t %s", $time, m);
		wrap_up();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rdr(a);
		chk(v, e);
	endtask
	task automatic clr();
		got.delete();
		ex.delete();
		sel.delete();
		st.delete();
	endtask
	// Gather n samples once the caller has armed, stop, compare in order
	task automatic collect(input int n);
		int i;
		for (i = 0; i < 40000 && got.size() < n; i++) @(posedge clk);
		if (got.size() < n) fail("samples");
		wrr(REG_CMD, 32'h2);
		for (i = 0; i < 200 && run; i++) @(posedge clk);
		if (run) fail("stop");
		foreach (ex[k]) chk(got[k], ex[k]);
	endtask
	initial begin
		int i;
		nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
		din = 24'h5A1234; cmp = 1'b0; err_total = 0; tests_run = 0;
		cnt_val = {64'h0, 32'h13572468, 32'h89ABCDEF};
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1 chk(rdata, 32'h0);
		chk({29'h0, run, buf_we, adc_start}, 32'h0);
		foreach (rows[r]) begin
			wrr(rows[r].a, rows[r].w);
			rc(rows[r].a, rows[r].e);
		end
		chk({trig_dac, trig_ch, trig_hyst, trig_fall}, {16'hBEEF, 15'h7FFF});
		wrr(REG_CFG, 32'h52); wrr(REG_CNT_CFG, 32'hE413); wrr(REG_GROUP_LEN, 32'h2);
		wrr(REG_TEMP_MASK, 32'h0); wrr(REG_DELAY_LO, 32'h3E8); wrr(REG_DELAY_HI, 32'h0);
		wrr(REG_TBL_ADDR, 32'h0); wrr(REG_TBL_DATA, 32'h3C5); wrr(REG_TBL_DATA, 32'hC2);
		wrr(REG_TBL_ADDR, 32'h0);
		rc(REG_TBL_DATA, 32'h385);
		chk(cnt_mode, 8'hE4);
		ex = '{16'h1234, 16'h005A, 16'hCDEF, 16'h89AB, 16'h2468, cv(2'h0, 6'h05),
			cv(2'h0, 6'h02), 16'h0000};
		ex = {ex, ex};
		wrr(REG_CMD, 32'h1);
		collect(16);
		chk(sel[0], {SRC_INPUT, 6'h05, 3'h6, 1'b1});
		chk(sel[1], {SRC_INPUT, 6'h02, 3'h3, 1'b0});
		chk(sel[2][11:10], SRC_ZERO);
		chk(32'(st[1] - st[0]), 32'h3E8);
		chk(32'(st[3] - st[0]), 32'h1388);
		rc(REG_WPTR, 32'(got.size()));
		clr();
		wrr(REG_CFG, 32'h11); wrr(REG_CNT_CFG, 32'h0); wrr(REG_GROUP_LEN, 32'h1);
		wrr(REG_TEMP_MASK, 32'h10); wrr(REG_DELAY_LO, 32'h0);
		ex = '{16'h0034, cv(SRC_INPUT, 6'h05), 16'h0034, cv(SRC_CJC, 6'h03),
			16'h0034, cv(SRC_CJC, 6'h04), 16'h0034, cv(SRC_CJC, 6'h05)};
		wrr(REG_CMD, 32'h1);
		collect(8);
		clr();
		wrr(REG_CFG, 32'h204); wrr(REG_TEMP_MASK, 32'h0); wrr(REG_TRIG_CFG, 32'h85);
		cmp <= 1'b1;
		repeat (5) @(posedge clk);
		wrr(REG_CMD, 32'h1);
		repeat (100) @(posedge clk);
		chk(run, 1'b0);
		rdr(REG_STATUS);
		chk(v[2], 1'b1);
		cmp <= 1'b0;
		repeat (10) @(posedge clk);
		cmp <= 1'b1;
		for (i = 0; i < 65 && !run; i++) @(posedge clk);
		chk(run, 1'b1);
		ex = '{cv(SRC_INPUT, 6'h05), cv(SRC_INPUT, 6'h05)};
		collect(2);
		chk(32'(st[1] - st[0]), 32'h3E8);
		chk(32'(st[4] - st[0]), 32'hFA0);
		wrap_up();
	end
endmodule
bind sqt_scan_seq sqt_scan_chk #(.MAX_DELAY_CYC(MAX_DELAY_CYC)) chk_i (
	.CLK(CLK), .NRST(NRST), .RD(RD), .RDATA(RDATA), .ADC_START(ADC_START),
	.ADC_SRC(ADC_SRC), .ADC_CH(ADC_CH), .ADC_RANGE(ADC_RANGE),
	.ADC_DIFF(ADC_DIFF), .BUF_WE(BUF_WE), .BUF_WADDR(BUF_WADDR), .RUN(RUN));
